/* File: rtl/irq_nest_regs.vh */
// Constants for the nested interrupt priority and macro service dispatcher.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef IRQ_NEST_REGS_VH
`define IRQ_NEST_REGS_VH
// Source count and priority level count
`define NSRC          23
`define NLVL          4
// Shared serial sources: default priorities
`define SRC_SER1      14
`define SRC_SER2      17
// Control word base address and spacing (bytes)
`define CW_BASE       16'hfe06
`define CW_STEP       16'h0002
// Control word addresses of note
`define CW_SER1       16'hfe24
`define CW_SER2       16'hfe2c
`define CW_LAST       16'hfe38
// In-service bit positions: levels 0..3, then non-maskable
`define ISB_NMI_LO    4
`define ISB_NMI_HI    7
// Mode register field: end vector suppress bit
`define MODE_VSUP_BIT 7
// Macro service kinds
`define MS_TYPE_A     2'h0
`define MS_TYPE_B     2'h1
`define MS_TYPE_C     2'h2
`define MS_COUNTER    2'h3
// Reset values
`define ISB_RESET     8'h00
`endif

/* File: rtl/irq_level_pick.v */
// Picks the winning source among eligible requests at one priority level.
// Assumes request and mask vectors are in default-priority order, bit 0 highest.
module irq_level_pick #(
  parameter N = 23,
  parameter W = 5
) (
  // Candidates
  input  wire [N-1:0] cand,
  // Result
  output reg          hit,
  output reg  [W-1:0] idx
);
  integer i;

  // Lowest index (highest default priority) wins
  always @* begin
    hit = 1'b0;
    idx = {W{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        hit = 1'b1;
        idx = i[W-1:0];
      end
    end
  end
endmodule // irq_level_pick

/* File: rtl/cw_addr_map.v */
// Maps a macro service source number to its control word address.
// Assumes source numbers equal default priorities 0..22.
`include "irq_nest_regs.vh"
module cw_addr_map #(
  parameter W = 5
) (
  // Source
  input  wire [W-1:0] src,
  // Address
  output reg  [15:0]  addr
);
  // Words are two bytes apart; gaps before the serial words and before source 19
  always @* begin
    if (src >= `SRC_SER2)
      addr = `CW_SER2 + {10'h000, src - 5'd17, 1'b0};
    else if (src >= `SRC_SER1)
      addr = `CW_SER1 + {10'h000, src - 5'd14, 1'b0};
    else
      addr = `CW_BASE + {10'h000, src, 1'b0};
    if (src == 5'd19)
      addr = 16'hfe32;
    else if (src == 5'd20)
      addr = 16'hfe34;
    else if (src == 5'd21)
      addr = 16'hfe36;
    else if (src == 5'd22)
      addr = `CW_LAST;
  end
endmodule // cw_addr_map

/* File: rtl/nested_irq_priority_macro_dispatch.v */
// Nested maskable interrupt acceptance and macro service dispatch.
// Assumes peripheral request levels and CPU instruction strobes synchronous to clk.
// Assumes each core strobe stands one cycle and cpu_ready marks instruction boundaries.
//
// How it works
// - A new request can be taken while an earlier service routine runs.
// - Fixed default order plus programmable per-source levels both steer arbitration.
// - Each maskable source sits at one of four levels, level 0 highest.
// - Taking any vectored interrupt clears the global enable flag.
// - Nothing in service and enable set: every maskable level is taken.
// - Enable clear, level 0 or non-maskable in service: macro service only.
// - Level 3 in service: nesting select picks all levels or 0..2.
// - Level 2 highest in service: only levels 0 and 1 vectored.
// - Level 1 highest in service: only level 0 vectored.
// - Macro service skips stacking and vector fetch, does a transfer.
// - After the programmed count runs out a vectored request is raised.
// - Twenty-three sources, four macro service kinds chosen per source.
// - Default priorities 0..22 with fixed control word addresses.
// - Async receive one and sync serial one share priority 14.
// - Async receive two and sync serial two share priority 17.
// - Timer matches take priorities 4..10 at two-byte steps.
// - Eligible when requested and unmasked; level then default order.
// - Accepting a vectored interrupt sets its level's in-service bit.
// - Macro service ignores the enable flag; only masks block it.
// - At count zero the suppress bit chooses vector or silence.
`include "irq_nest_regs.vh"
module nested_irq_priority_macro_dispatch #(
  parameter NSRC = 23,
  parameter SW   = 5
) (
  // Clock and reset
  input  wire              clk,
  input  wire              rst,
  // Peripheral requests and per-source settings
  input  wire [NSRC-1:0]   req_flags,
  input  wire [NSRC-1:0]   mask_flags,
  input  wire [NSRC-1:0]   macro_enable,
  input  wire [2*NSRC-1:0] prio_levels,
  input  wire [2*NSRC-1:0] macro_kinds,
  input  wire [NSRC-1:0]   end_vector_suppress_bit,
  input  wire              serial1_sync_mode,
  input  wire              serial2_sync_mode,
  // CPU core state and strobes
  input  wire              level3_nesting_select,
  input  wire              enable_interrupts_instruction,
  input  wire              disable_interrupts_instruction,
  input  wire              return_from_interrupt_instruction,
  input  wire              nmi_accept,
  input  wire              nmi_is_watchdog,
  input  wire              macro_done,
  input  wire              macro_count_zero,
  input  wire              cpu_ready,
  // Dispatch outputs
  output reg               vector_take,
  output reg               macro_take,
  output reg  [SW-1:0]     take_src,
  output reg  [1:0]        take_level,
  output reg  [1:0]        take_kind,
  output reg  [15:0]       take_cw_addr,
  output reg               skip_context_save,
  output reg  [NSRC-1:0]   req_clear,
  output reg               serial1_is_sync,
  output reg               serial2_is_sync,
  // Core state view
  output reg               global_irq_enable_flag,
  output reg  [7:0]        in_service_level_bits,
  output reg  [NSRC-1:0]   end_vector_pending
);
  // State
  reg              ie_q;
  reg              ie_d;
  reg  [7:0]       isb_q;
  reg  [7:0]       isb_d;
  reg  [NSRC-1:0]  endv_q;
  reg  [NSRC-1:0]  endv_d;
  reg  [SW-1:0]    msrc_q;

  // In-service decode; non-maskable bits outrank every level
  wire             nmi_busy  = |isb_q[`ISB_NMI_HI:`ISB_NMI_LO];
  wire             lvl_any   = |isb_q[3:0];
  wire             lvl0_busy = isb_q[0];
  wire             lvl1_top  = ~lvl0_busy & isb_q[1];
  wire             lvl2_top  = ~lvl0_busy & ~isb_q[1] & isb_q[2];
  wire             lvl3_top  = ~lvl0_busy & ~isb_q[1] & ~isb_q[2] & isb_q[3];
  wire             idle_isb  = ~nmi_busy & ~lvl_any;

  // Vectored route: plain sources, or macro sources whose count ran out
  wire [NSRC-1:0]  vec_route = ~macro_enable | endv_q;

  // Count ran out and the end vector is not suppressed
  wire             endv_set  = macro_done & macro_count_zero & ~end_vector_suppress_bit[msrc_q];

  // Eligibility and level split
  wire [NSRC-1:0]  elig = (req_flags | endv_q) & ~mask_flags;
  wire [NSRC-1:0]  ms_cand = req_flags & ~mask_flags & macro_enable;
  reg  [NSRC-1:0]  vcand [0:3];
  integer          k;

  always @* begin
    for (k = 0; k < 4; k = k + 1)
      vcand[k] = {NSRC{1'b0}};
    for (k = 0; k < NSRC; k = k + 1)
      if (elig[k] & vec_route[k])
        vcand[prio_levels[2*k +: 2]][k] = 1'b1;
  end

  // One picker per level, default order breaks ties
  wire [3:0]       lvl_hit;
  wire [SW-1:0]    lvl_idx [0:3];
  wire             ms_hit;
  wire [SW-1:0]    ms_idx;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lvl
      irq_level_pick #(.N(NSRC), .W(SW)) u_pick (
        .cand (vcand[g]),
        .hit  (lvl_hit[g]),
        .idx  (lvl_idx[g])
      );
    end
  endgenerate

  irq_level_pick #(.N(NSRC), .W(SW)) u_ms_pick (
    .cand (ms_cand),
    .hit  (ms_hit),
    .idx  (ms_idx)
  );

  // Highest accepted level from in-service state
  reg  [3:0] lvl_ok;
  always @* begin
    lvl_ok = 4'b0000;
    if (ie_q && !nmi_busy && !lvl0_busy) begin
      if (lvl1_top)
        lvl_ok = 4'b0001;
      else if (lvl2_top)
        lvl_ok = 4'b0011;
      else if (lvl3_top)
        lvl_ok = level3_nesting_select ? 4'b0111 : 4'b1111;
      else if (idle_isb)
        lvl_ok = 4'b1111;
    end
  end

  // Best accepted vectored request
  reg          v_hit;
  reg  [1:0]   v_lvl;
  reg  [SW-1:0] v_idx;
  integer       m;
  always @* begin
    v_hit = 1'b0;
    v_lvl = 2'h0;
    v_idx = {SW{1'b0}};
    for (m = 3; m >= 0; m = m - 1) begin
      if (lvl_hit[m] && lvl_ok[m]) begin
        v_hit = 1'b1;
        v_lvl = m[1:0];
        v_idx = lvl_idx[m];
      end
    end
  end

  // Macro service goes first; it needs no enable
  wire do_ms  = cpu_ready & ms_hit;
  // A vectored take yields to macro service and to a non-maskable accept
  wire vec_gate = cpu_ready & ~ms_hit & ~nmi_accept;
  wire do_vec   = vec_gate & v_hit;
  wire any_take = do_ms | do_vec;
  wire [SW-1:0] pick_src = do_ms ? ms_idx : v_idx;
  wire [15:0]   pick_addr;

  // Level and kind of the chosen source
  wire [1:0]    ms_lvl    = prio_levels[2*ms_idx +: 2];
  wire [1:0]    pick_lvl  = do_ms ? ms_lvl : v_lvl;
  wire [1:0]    pick_kind = macro_kinds[2*pick_src +: 2];

  cw_addr_map #(.W(SW)) u_map (
    .src  (pick_src),
    .addr (pick_addr)
  );

  // Top in-service bit: non-maskable first, then level 0 upward
  reg  [7:0] ret_clr;
  always @* begin
    ret_clr = 8'h00;
    if (isb_q[7])
      ret_clr = 8'h80;
    else if (isb_q[6])
      ret_clr = 8'h40;
    else if (isb_q[0])
      ret_clr = 8'h01;
    else if (isb_q[1])
      ret_clr = 8'h02;
    else if (isb_q[2])
      ret_clr = 8'h04;
    else if (isb_q[3])
      ret_clr = 8'h08;
  end

  // Global enable flag: accepts clear it, disable beats enable
  always @* begin
    ie_d = ie_q;
    if (enable_interrupts_instruction)
      ie_d = 1'b1;
    if (disable_interrupts_instruction)
      ie_d = 1'b0;
    if (do_vec || nmi_accept)
      ie_d = 1'b0;
  end

  // In-service bits: return clears the top one, accepts set theirs
  always @* begin
    isb_d = isb_q;
    if (return_from_interrupt_instruction)
      isb_d = isb_q & ~ret_clr;
    if (do_vec)
      isb_d[v_lvl] = 1'b1;
    if (nmi_accept) begin
      if (nmi_is_watchdog)
        isb_d[6] = 1'b1;
      else
        isb_d[7] = 1'b1;
    end
  end

  // End-of-count vector requests; set wins over clear
  always @* begin
    endv_d = endv_q;
    if (do_vec)
      endv_d[v_idx] = 1'b0;
    if (endv_set)
      endv_d[msrc_q] = 1'b1;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ie_q   <= 1'b0;
      isb_q  <= `ISB_RESET;
      endv_q <= {NSRC{1'b0}};
      msrc_q <= {SW{1'b0}};
    end else begin
      ie_q   <= ie_d;
      isb_q  <= isb_d;
      endv_q <= endv_d;
      if (do_ms)
        msrc_q <= ms_idx;
    end
  end

  // Registered dispatch pulses and the chosen source's details
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      vector_take       <= 1'b0;
      macro_take        <= 1'b0;
      skip_context_save <= 1'b0;
      take_src          <= {SW{1'b0}};
      take_level        <= 2'h0;
      take_kind         <= `MS_TYPE_A;
      take_cw_addr      <= 16'h0000;
      req_clear         <= {NSRC{1'b0}};
    end else begin
      vector_take       <= do_vec;
      macro_take        <= do_ms;
      skip_context_save <= do_ms;
      take_src          <= pick_src;
      take_level        <= pick_lvl;
      take_kind         <= pick_kind;
      take_cw_addr      <= pick_addr;
      req_clear         <= {NSRC{1'b0}};
      if (any_take)
        req_clear[pick_src] <= 1'b1;
    end
  end

  // Shared serial hardware: echo which use is active
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      serial1_is_sync <= 1'b0;
      serial2_is_sync <= 1'b0;
    end else begin
      serial1_is_sync <= serial1_sync_mode;
      serial2_is_sync <= serial2_sync_mode;
    end
  end

  // Core state view, updated on the same edge as the internal state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      global_irq_enable_flag <= 1'b0;
      in_service_level_bits  <= `ISB_RESET;
      end_vector_pending     <= {NSRC{1'b0}};
    end else begin
      global_irq_enable_flag <= ie_d;
      in_service_level_bits  <= isb_d;
      end_vector_pending     <= endv_d;
    end
  end
endmodule // nested_irq_priority_macro_dispatch

/* File: dv/nested_irq_checks_assertions.sv */
// Concurrent checks on the dispatcher's acceptance and dispatch outputs.
// Assumes binding onto the dispatcher top; sees only its ports.
module nested_irq_checks #(
  parameter NSRC = 23,
  parameter SW   = 5
) (
  // Clock and reset
  input logic          clk,
  input logic          rst,
  // Core strobes
  input logic          level3_nesting_select,
  input logic          return_from_interrupt_instruction,
  // Dispatch results
  input logic          vector_take,
  input logic          macro_take,
  input logic          skip_context_save,
  input logic [SW-1:0] take_src,
  input logic [1:0]    take_level,
  input logic [15:0]   take_cw_addr,
  // Core state
  input logic          global_irq_enable_flag,
  input logic [7:0]    in_service_level_bits
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Return with levels 0 and 1 both in service, no non-maskable
  sequence ret_two_levels;
    return_from_interrupt_instruction && in_service_level_bits[7:4] == 4'h0 && in_service_level_bits[1:0] == 2'b11;
  endsequence
  chk_take_clears_ie: assert property (vector_take |-> !global_irq_enable_flag)
    else $error("vector take left enable set");
  chk_take_sets_isb: assert property (vector_take |-> in_service_level_bits[take_level])
    else $error("in-service bit of taken level not set");
  chk_vec_blocked: assert property (vector_take |-> $past(global_irq_enable_flag)
    && $past(in_service_level_bits[7:4]) == 4'h0 && !$past(in_service_level_bits[0]))
    else $error("vector taken while only macro allowed");
  chk_lvl1_nest: assert property (vector_take && $past(in_service_level_bits[1:0]) == 2'b10
    |-> take_level == 2'h0) else $error("level 1 let a lower level in");
  chk_lvl2_nest: assert property (vector_take && $past(in_service_level_bits[2:0]) == 3'b100
    |-> take_level <= 2'h1) else $error("level 2 let a lower level in");
  chk_lvl3_select: assert property (vector_take && $past(in_service_level_bits[3:0]) == 4'h8
    && $past(level3_nesting_select) |-> take_level != 2'h3) else $error("level 3 nested with select set");
  chk_macro_no_stack: assert property (macro_take |-> skip_context_save && !vector_take)
    else $error("macro take without context skip");
  chk_cw_address: assert property ((vector_take || macro_take) && take_src <= 13
    |-> take_cw_addr == 16'hfe06 + {take_src, 1'b0}) else $error("control word address wrong");
  chk_ret_clears_top: assert property (ret_two_levels |=> !in_service_level_bits[0]
    && in_service_level_bits[1]) else $error("return cleared wrong bit");
endmodule // nested_irq_checks

bind nested_irq_priority_macro_dispatch nested_irq_checks #(.NSRC(NSRC), .SW(SW)) i_nested_irq_checks (.*);

/* File: dv/irq_source_model.sv */
// Far-side model: peripheral request flags and the macro transfer engine.
// Assumes shared clock and reset; raise is a one-cycle pulse from the bench.
module irq_source_model #(
  parameter NSRC = 23
) (
  // Clock and reset
  input  logic            clk,
  input  logic            rst,
  // Bench control
  input  logic [NSRC-1:0] raise,
  input  logic            count_zero_in,
  // Dispatcher side
  input  logic [NSRC-1:0] req_clear,
  input  logic            macro_take,
  output logic [NSRC-1:0] req_flags,
  output logic            macro_done,
  output logic            macro_count_zero
);
  timeunit 1ns;
  timeprecision 100ps;
  // Flags held until cleared; transfer finishes one cycle after a take
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_flags <= '0;
      macro_done <= 1'b0;
    end else begin
      req_flags <= (req_flags & ~req_clear) | raise;
      macro_done <= macro_take;
    end
  end
  // Count state only meaningful with the done strobe
  assign macro_count_zero = macro_done & count_zero_in;
endmodule // irq_source_model

/* File: dv/nested_irq_priority_macro_dispatch_test.sv */
// Self-checking bench for the nested interrupt dispatcher.
// Assumes the far-side model raises requests and completes transfers.
module nested_irq_priority_macro_dispatch_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, serial1_sync_mode, serial2_sync_mode, level3_nesting_select, enable_interrupts_instruction;
  logic disable_interrupts_instruction, return_from_interrupt_instruction, nmi_accept, nmi_is_watchdog;
  logic cpu_ready, macro_done, macro_count_zero, count_zero_in, vector_take, macro_take, skip_context_save;
  logic serial1_is_sync, serial2_is_sync, global_irq_enable_flag;
  logic [22:0] raise, req_flags, mask_flags, macro_enable, end_vector_suppress_bit, req_clear, end_vector_pending;
  logic [45:0] prio_levels, macro_kinds;
  logic [4:0]  take_src;
  logic [1:0]  take_level, take_kind;
  logic [15:0] take_cw_addr;
  logic [7:0]  in_service_level_bits;
  int          n_mismatch, n_checks, cyc;
  logic [4:0]  msrc [4] = '{5'd14, 5'd17, 5'd19, 5'd22};
  logic [15:0] mcw [4] = '{16'hfe24, 16'hfe2c, 16'hfe32, 16'hfe38};

  nested_irq_priority_macro_dispatch #(.NSRC(23), .SW(5)) i_nested_irq_priority_macro_dispatch (.*);
  irq_source_model #(.NSRC(23)) i_irq_source_model (.*);

  // Clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      finish_test();
    end
  end

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One dispatch slot: raise, then one ready edge; answer visible on return
  task automatic fire(logic [22:0] r);
    @(posedge clk) #1;
    raise = r;
    @(posedge clk) #1;
    raise = '0;
    cpu_ready = 1;
    @(posedge clk) #1;
    cpu_ready = 0;
  endtask
  task automatic expect_take(logic v, logic m, logic [4:0] s, logic [1:0] l, logic [7:0] isb);
    check("vector_take", vector_take, v);
    check("macro_take", macro_take, m);
    if (v | m) check("take_src", take_src, s);
    if (v) check("take_level", take_level, l);
    if (v) check("enable", global_irq_enable_flag, 0);
    if ((v | m) && s < 14) check("take_cw_addr", take_cw_addr, 16'hfe06 + 2 * s);
    check("in_service", in_service_level_bits, isb);
  endtask
  task automatic pulse_ei();
    enable_interrupts_instruction = 1;
    @(posedge clk) #1;
    enable_interrupts_instruction = 0;
    check("enable", global_irq_enable_flag, 1);
  endtask
  task automatic pulse_ret(logic [7:0] isb);
    return_from_interrupt_instruction = 1;
    @(posedge clk) #1;
    return_from_interrupt_instruction = 0;
    check("in_service", in_service_level_bits, isb);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    rst = 1;
    {serial1_sync_mode, serial2_sync_mode, count_zero_in} = 3'h7;
    {level3_nesting_select, enable_interrupts_instruction, disable_interrupts_instruction} = 3'h0;
    {return_from_interrupt_instruction, nmi_accept, nmi_is_watchdog, cpu_ready} = 4'h0;
    raise = '0;
    mask_flags = 23'h001000;
    macro_enable = 23'h7a7000;
    end_vector_suppress_bit = 23'h7a4000;
    prio_levels = 46'h3fff_ffff_ffff;
    prio_levels[15:8] = 8'h36;
    macro_kinds = '0;
    for (int k = 0; k < 4; k++) macro_kinds[2 * msrc[k] +: 2] = k[1:0];
    repeat (4) @(posedge clk);
    #1 rst = 0;
    fire(23'h003004);
    expect_take(0, 1, 13, 0, 8'h00);
    check("skip_context_save", skip_context_save, 1);
    repeat (2) @(posedge clk) #1;
    check("end_vector_pending", end_vector_pending[13], 1);
    check("serial_sync", {serial1_is_sync, serial2_is_sync}, 2'h3);
    for (int k = 0; k < 4; k++) begin
      fire(23'h1 << msrc[k]);
      expect_take(0, 1, msrc[k], 0, 8'h00);
      check("take_kind", take_kind, k);
      check("take_cw_addr", take_cw_addr, mcw[k]);
    end
    repeat (2) @(posedge clk) #1;
    check("end_vector_pending", end_vector_pending, 23'h002000);
    pulse_ei();
    fire(0);
    expect_take(1, 0, 2, 3, 8'h08);
    check("req_clear", req_clear, 23'h000004);
    pulse_ei();
    level3_nesting_select = 1;
    fire(0);
    expect_take(0, 0, 0, 0, 8'h08);
    level3_nesting_select = 0;
    fire(0);
    expect_take(1, 0, 13, 3, 8'h08);
    pulse_ei();
    level3_nesting_select = 1;
    fire(23'h000030);
    expect_take(1, 0, 5, 1, 8'h0a);
    pulse_ei();
    fire(0);
    expect_take(0, 0, 0, 0, 8'h0a);
    fire(23'h000080);
    expect_take(1, 0, 7, 0, 8'h0b);
    pulse_ei();
    fire(0);
    expect_take(0, 0, 0, 0, 8'h0b);
    pulse_ret(8'h0a);
    pulse_ret(8'h08);
    fire(0);
    expect_take(1, 0, 4, 2, 8'h0c);
    pulse_ei();
    prio_levels[19:16] = 4'h6;
    fire(23'h000100);
    expect_take(0, 0, 0, 0, 8'h0c);
    fire(23'h000200);
    expect_take(1, 0, 9, 1, 8'h0e);
    pulse_ei();
    nmi_is_watchdog = 1;
    nmi_accept = 1;
    @(posedge clk) #1;
    nmi_accept = 0;
    check("in_service", in_service_level_bits, 8'h4e);
    check("enable", global_irq_enable_flag, 0);
    pulse_ei();
    fire(23'h004000);
    expect_take(0, 1, 14, 0, 8'h4e);
    fire(0);
    expect_take(0, 0, 0, 0, 8'h4e);
    pulse_ret(8'h0e);
    disable_interrupts_instruction = 1;
    enable_interrupts_instruction = 1;
    @(posedge clk) #1;
    {disable_interrupts_instruction, enable_interrupts_instruction} = 2'h0;
    check("enable", global_irq_enable_flag, 0);
    finish_test();
  end
endmodule // nested_irq_priority_macro_dispatch_test
